// ===== dv/dcdac_bus_master.sv
// Behavioural bus master that drives the serial clock and data lines
`default_nettype none

module dcdac_bus_master
(
	input wire logic i_clk_sys,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Bit level, 13 system clocks (65 ns, nearest to 64 ns) per bit, moved on clock edges
	// ----------------------------------------------------------------
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	task automatic qtr();
		repeat (3) @(posedge i_clk_sys);
	endtask

	// The slave lets go of SDA three clocks after a fall; change data one clock later
	task automatic put_bit(input logic b);
		qtr();
		@(posedge i_clk_sys);
		o_sda <= b;
		qtr();
		o_scl <= 1'b1;
		qtr();
		qtr();
		o_scl <= 1'b0;
	endtask

	// Releases data early in the low phase so the slave can take the line
	task automatic get_bit(output logic b);
		qtr();
		@(posedge i_clk_sys);
		o_sda <= 1'b1;
		qtr();
		o_scl <= 1'b1;
		qtr();
		b = i_sda;
		qtr();
		o_scl <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Conditions and bytes
	// ----------------------------------------------------------------
	task automatic start();
		qtr();
		o_sda <= 1'b1;
		qtr();
		o_scl <= 1'b1;
		qtr();
		qtr();
		o_sda <= 1'b0;
		qtr();
		qtr();
		o_scl <= 1'b0;
	endtask

	task automatic stop();
		qtr();
		o_sda <= 1'b0;
		qtr();
		o_scl <= 1'b1;
		qtr();
		qtr();
		o_sda <= 1'b1;
		qtr();
	endtask

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(b);
		ack = ~b;
	endtask

	task automatic rd_byte(output logic [7:0] d, input logic nack);
		for (int i = 7; i >= 0; i--)
			get_bit(d[i]);
		put_bit(nack);
	endtask
endmodule // dcdac_bus_master

`default_nettype wire

// ===== dv/dual_current_dac_i2c_regs_test.sv
// Self-checking bench for the dual current DAC serial control slave
`default_nettype none

module dual_current_dac_i2c_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import dcdac_pkg::*;

	localparam int LIMIT = 40000;
	logic clk;
	logic srst;
	logic scl;
	logic mst_sda;
	logic sda_o, sda_oe, idle, a_snk, a_src, b_snk, b_src;
	dcdac_mag_t a_code;
	dcdac_mag_t b_code;
	int err_total = 0;
	int comparisons = 0;
	int cyc = 0;
	logic [7:0] ea = 8'h00;
	logic [7:0] eb = 8'h00;
	logic [15:0] tbl [4] = '{16'hF88A, 16'hF90F, 16'hF9F5, 16'hF880};

	// Open-drain data line with pull-up
	wire logic sda_bus = mst_sda & (sda_oe ? sda_o : 1'b1);

	dcdac_i2c_top i_dut (.i_clk_sys(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda_bus),
		.o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_bus_idle(idle),
		.o_current_output_a_sink(a_snk), .o_current_output_a_source(a_src),
		.o_current_output_a_magnitude_code(a_code),
		.o_current_output_b_sink(b_snk), .o_current_output_b_source(b_src),
		.o_current_output_b_magnitude_code(b_code));

	dcdac_bus_master i_mst (.i_clk_sys(clk), .i_sda(sda_bus), .o_scl(scl), .o_sda(mst_sda));

	// ----------------------------------------------------------------
	// Checking and access tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// Zero code keeps both direction flags low
	task automatic chk_ch(input logic [7:0] a, input logic [7:0] b);
		chk("channel a", {2'h0, a_snk, a_src, a_code},
			{2'h0, ~a[7] & (|a[3:0]), a[7] & (|a[3:0]), a[3:0]});
		chk("channel b", {2'h0, b_snk, b_src, b_code},
			{2'h0, ~b[7] & (|b[3:0]), b[7] & (|b[3:0]), b[3:0]});
	endtask

	task automatic wr(input logic [7:0] adr, input logic [7:0] rg, input logic [7:0] d,
		input logic ack_exp);
		logic ack;
		i_mst.start();
		i_mst.wr_byte(adr, ack);
		chk("address ack", {7'h00, ack}, {7'h00, ack_exp});
		i_mst.wr_byte(rg, ack);
		chk("register ack", {7'h00, ack}, {7'h00, ack_exp});
		i_mst.wr_byte(d, ack);
		chk("data ack", {7'h00, ack}, {7'h00, ack_exp});
		i_mst.stop();
	endtask

	task automatic rd(input logic [7:0] rg, input logic [7:0] exp);
		logic ack;
		logic [7:0] d;
		i_mst.start();
		i_mst.wr_byte(8'h90, ack);
		i_mst.wr_byte(rg, ack);
		i_mst.start();
		i_mst.wr_byte(8'h91, ack);
		chk("read address ack", {7'h00, ack}, 8'h01);
		i_mst.rd_byte(d, 1'b1);
		i_mst.stop();
		chk("read data", d, exp);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d, err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			err_total++;
			wrap_up();
		end
	end

	initial
	begin
		srst = 1'b1;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		repeat (5) @(posedge clk);
		chk_ch(ea, eb);
		chk("idle", {7'h00, idle}, 8'h01);
		i_mst.start();
		repeat (4) @(posedge clk);
		chk("idle in frame", {7'h00, idle}, 8'h00);
		i_mst.stop();
		repeat (4) @(posedge clk);
		chk("idle after stop", {7'h00, idle}, 8'h01);
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h90, tbl[i][15:8], tbl[i][7:0], 1'b1);
			if (tbl[i][8])
				eb = tbl[i][7:0];
			else
				ea = tbl[i][7:0];
			chk_ch(ea, eb);
		end
		rd(8'hF8, {ea[7], 3'h0, ea[3:0]});
		rd(8'hF9, {eb[7], 3'h0, eb[3:0]});
		wr(8'h92, 8'hF8, 8'h03, 1'b0);
		chk_ch(ea, eb);
		wr(8'h90, 8'h10, 8'h55, 1'b1);
		chk_ch(ea, eb);
		rd(8'h10, 8'h00);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk_ch(8'h00, 8'h00);
		wrap_up();
	end
endmodule // dual_current_dac_i2c_regs_test

`default_nettype wire

// ===== rtl/dcdac_consts.svh
// Constants of the dual current DAC serial control slave
`ifndef DCDAC_CONSTS_SVH
`define DCDAC_CONSTS_SVH

// ----------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------
`define DCDAC_SLAVE_ADDR 7'h48
`define DCDAC_REG_A 8'hF8
`define DCDAC_REG_B 8'hF9
`define DCDAC_NUM_OUT 2

// ----------------------------------------------------------------
// Control register layout and reset values
// ----------------------------------------------------------------
`define DCDAC_DIR_BIT 7
`define DCDAC_MAG_MSB 3
`define DCDAC_MAG_W 4
`define DCDAC_MAG_STEPS 15
`define DCDAC_SETTING_RST 5'h00
`define DCDAC_READ_PAD 3'h0
`define DCDAC_BYTE_BITS 4'h8
`define DCDAC_PIN_RST 2'h3

`endif

// ===== rtl/dcdac_i2c_top.sv
// Serial control slave for a two-channel sink/source current DAC
`include "dcdac_consts.svh"
`default_nettype none

// Notes on behaviour
// - Two outputs, fifteen sink and source steps
// - Power-up gives zero current on both outputs
// - First register 0xF8, second 0xF9
// - Bit 7 picks sink (0) or source (1)
// - Bits 3..0 magnitude; zero code gives none
// - Each code step is one fifteenth full scale
// - Answer only to address bytes 90h (write) and 91h (read)
// - SDA falling with SCL high starts transfer
// - SDA rising with SCL high ends transfer
// - Repeated start begins a fresh transfer
// - SDA changes only while SCL is low
// - Incoming bits sampled on SCL rise
// - Outgoing bits driven after SCL fall
// - Bus idle between stop and start, lines high
// - Wrong address: ignore until next start
// - Receiver acknowledges low on ninth clock
module dcdac_i2c_top
#(
	parameter logic [6:0] P_SLAVE_ADDR = `DCDAC_SLAVE_ADDR
)
(
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_o,
	output logic o_sda_oe,
	output logic o_bus_idle,
	output logic o_current_output_a_sink,
	output logic o_current_output_a_source,
	output var dcdac_pkg::dcdac_mag_t o_current_output_a_magnitude_code,
	output logic o_current_output_b_sink,
	output logic o_current_output_b_source,
	output var dcdac_pkg::dcdac_mag_t o_current_output_b_magnitude_code
);
	import dcdac_pkg::*;

	dcdac_line_if line ();

	dcdac_state_t state_r;
	dcdac_state_t after_ack_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] tx_r;
	logic [7:0] ptr_r;
	logic drive_r;
	logic idle_r;
	dcdac_setting_t setting_r [`DCDAC_NUM_OUT];
	logic [`DCDAC_NUM_OUT-1:0] sink_w;
	logic [`DCDAC_NUM_OUT-1:0] source_w;
	dcdac_mag_t mag_w [`DCDAC_NUM_OUT];
	logic byte_full;
	logic addr_hit;
	logic write_strobe;
	logic [7:0] read_value;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] offset_of(input int idx);
		offset_of = 8'(`DCDAC_REG_A + idx);
	endfunction

	function automatic dcdac_state_t next_after(input dcdac_state_t st, input logic rd);
		unique case (st)
			ST_ADDR: next_after = rd ? ST_READ : ST_REG;
			ST_REG: next_after = ST_DATA;
			default: next_after = ST_DATA;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	dcdac_pin_sync u_pin_sync
	(
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.line(line)
	);

	assign byte_full = (bit_cnt_r == `DCDAC_BYTE_BITS);
	assign addr_hit = (shift_r[7:1] == P_SLAVE_ADDR);
	assign write_strobe = (state_r == ST_DATA) && line.scl_fall && byte_full;

	// Unmapped pointer reads as zero; reserved bits always read zero
	always_comb
	begin
		read_value = '0;
		for (int i = 0; i < `DCDAC_NUM_OUT; i++)
		begin
			if (ptr_r == offset_of(i))
				read_value = {setting_r[i].source, `DCDAC_READ_PAD, setting_r[i].mag};
		end
	end

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	// SDA is only ever pulled low, never driven high: open-drain pin
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			state_r <= ST_IDLE;
			after_ack_r <= ST_IDLE;
			bit_cnt_r <= '0;
			shift_r <= '0;
			tx_r <= '0;
			drive_r <= 1'b0;
		end
		else if (line.start)
		begin
			state_r <= ST_ADDR;
			bit_cnt_r <= '0;
			drive_r <= 1'b0;
		end
		else if (line.stop)
		begin
			state_r <= ST_IDLE;
			bit_cnt_r <= '0;
			drive_r <= 1'b0;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE, ST_IGNORE:
				begin
					drive_r <= 1'b0;
				end
				ST_ADDR, ST_REG, ST_DATA:
				begin
					if (line.scl_rise && !byte_full)
					begin
						shift_r <= {shift_r[6:0], line.sda};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					else if (line.scl_fall && byte_full)
					begin
						bit_cnt_r <= '0;
						if (state_r != ST_ADDR || addr_hit)
						begin
							state_r <= ST_ACK;
							drive_r <= 1'b1;
							after_ack_r <= next_after(state_r, shift_r[0]);
						end
						else
						begin
							state_r <= ST_IGNORE;
						end
					end
				end
				ST_ACK:
				begin
					if (line.scl_fall)
					begin
						state_r <= after_ack_r;
						if (after_ack_r == ST_READ)
						begin
							tx_r <= read_value;
							drive_r <= !read_value[7];
						end
						else
						begin
							drive_r <= 1'b0;
						end
					end
				end
				ST_READ:
				begin
					if (line.scl_rise)
					begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					else if (line.scl_fall)
					begin
						if (byte_full)
						begin
							// Let go so the master can answer on the ninth clock
							drive_r <= 1'b0;
							bit_cnt_r <= '0;
							state_r <= ST_READ_ACK;
						end
						else
						begin
							tx_r <= {tx_r[6:0], 1'b0};
							drive_r <= !tx_r[6];
						end
					end
				end
				ST_READ_ACK:
				begin
					if (line.scl_rise)
					begin
						// Not-acknowledge ends the read; an ack reloads at the fall
						state_r <= line.sda ? ST_IGNORE : ST_ACK;
						after_ack_r <= ST_READ;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Register pointer and settings
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			ptr_r <= '0;
		else if ((state_r == ST_REG) && line.scl_fall && byte_full)
			ptr_r <= shift_r;
	end

	// A pointer outside the map is acknowledged and its data dropped
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			for (int i = 0; i < `DCDAC_NUM_OUT; i++)
				setting_r[i] <= `DCDAC_SETTING_RST;
		end
		else if (write_strobe)
		begin
			for (int i = 0; i < `DCDAC_NUM_OUT; i++)
			begin
				if (ptr_r == offset_of(i))
					setting_r[i] <= {shift_r[`DCDAC_DIR_BIT], shift_r[`DCDAC_MAG_MSB:0]};
			end
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			idle_r <= 1'b0;
		else
			idle_r <= (state_r == ST_IDLE) && line.scl && line.sda;
	end

	// ----------------------------------------------------------------
	// Analog controls
	// ----------------------------------------------------------------
	generate
		for (genvar g = 0; g < `DCDAC_NUM_OUT; g++)
		begin : g_out
			dcdac_out_drive u_out_drive
			(
				.i_clk_sys(i_clk_sys),
				.i_srst(i_srst),
				.i_setting(setting_r[g]),
				.o_sink(sink_w[g]),
				.o_source(source_w[g]),
				.o_magnitude_code(mag_w[g])
			);
		end
	endgenerate

	// The clock pin is input only; the master owns every pulse
	assign o_sda_o = 1'b0;
	assign o_sda_oe = drive_r;
	assign o_bus_idle = idle_r;
	assign o_current_output_a_sink = sink_w[0];
	assign o_current_output_a_source = source_w[0];
	assign o_current_output_a_magnitude_code = mag_w[0];
	assign o_current_output_b_sink = sink_w[1];
	assign o_current_output_b_source = source_w[1];
	assign o_current_output_b_magnitude_code = mag_w[1];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_srst);

	a_reset_zero: assert property ($fell(i_srst) |->
		setting_r[0] == '0 && setting_r[1] == '0 && !o_sda_oe)
		else $error("settings not zero after reset");

	a_start_addr: assert property (line.start |=> state_r == ST_ADDR && !o_sda_oe)
		else $error("start did not open address phase");

	a_stop_idle: assert property (line.stop && !line.start |=> state_r == ST_IDLE)
		else $error("stop did not return to idle");

	a_sda_low_scl: assert property ($changed(drive_r) && !$past(line.start) && !$past(line.stop)
		|-> !line.scl)
		else $error("sda drive changed while scl high");

	a_addr_ack: assert property (state_r == ST_ADDR && line.scl_fall && byte_full && addr_hit
		|=> state_r == ST_ACK && o_sda_oe [*2])
		else $error("own address not acknowledged");

	a_addr_ignore: assert property (state_r == ST_ADDR && line.scl_fall && byte_full && !addr_hit
		|=> state_r == ST_IGNORE && !o_sda_oe)
		else $error("foreign address not ignored");

	a_ignore_hold: assert property (state_r == ST_IGNORE && !line.start && !line.stop
		|=> state_r == ST_IGNORE && !o_sda_oe)
		else $error("left ignore without start or stop");

	a_sample_rise: assert property ((state_r == ST_REG) && line.scl_rise && !byte_full
		|=> shift_r[0] == $past(line.sda) && bit_cnt_r == $past(bit_cnt_r) + 4'h1)
		else $error("data bit not sampled on scl rise");

	a_write_reg_a: assert property (write_strobe && ptr_r == `DCDAC_REG_A
		|=> setting_r[0] == {$past(shift_r[7]), $past(shift_r[3:0])})
		else $error("write to first register lost");

	a_zero_mag: assert property (setting_r[1].mag == '0 |=>
		!o_current_output_b_sink && !o_current_output_b_source)
		else $error("current flows with zero code");

	a_read_first: assert property (state_r == ST_ACK && after_ack_r == ST_READ && line.scl_fall
		|=> o_sda_oe == !tx_r[7] && state_r == ST_READ)
		else $error("first read bit not driven after fall");

	c_write_a: cover property (write_strobe && ptr_r == `DCDAC_REG_A);
	c_read_nack: cover property (state_r == ST_READ_ACK && line.scl_rise && line.sda);
	c_rep_start: cover property (state_r == ST_DATA && line.start);
	c_foreign: cover property (state_r == ST_IGNORE);
endmodule // dcdac_i2c_top

`default_nettype wire

// ===== rtl/dcdac_line_if.sv
// Synchronised bus lines and their events, from sampler to protocol logic
`default_nettype none

interface dcdac_line_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;

	modport src (output scl, output sda, output scl_rise, output scl_fall,
		output start, output stop);
	modport snk (input scl, input sda, input scl_rise, input scl_fall,
		input start, input stop);
endinterface

`default_nettype wire

// ===== rtl/dcdac_out_drive.sv
// Decode of one control setting into the analog DAC controls
`include "dcdac_consts.svh"
`default_nettype none

module dcdac_out_drive
(
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire dcdac_pkg::dcdac_setting_t i_setting,
	output logic o_sink,
	output logic o_source,
	output var dcdac_pkg::dcdac_mag_t o_magnitude_code
);
	import dcdac_pkg::*;

	logic active;

	// A zero code means no current whatever the direction says
	assign active = |i_setting.mag;

	// ----------------------------------------------------------------
	// Registered controls
	// ----------------------------------------------------------------
	// The analog side scales the code in fifteen equal steps
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			o_sink <= 1'b0;
			o_source <= 1'b0;
			o_magnitude_code <= '0;
		end
		else
		begin
			o_sink <= active && !i_setting.source;
			o_source <= active && i_setting.source;
			o_magnitude_code <= i_setting.mag;
		end
	end
endmodule // dcdac_out_drive

`default_nettype wire

// ===== rtl/dcdac_pin_sync.sv
// Two-stage synchroniser and edge/condition detector for the bus pins
`include "dcdac_consts.svh"
`default_nettype none

module dcdac_pin_sync
(
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_scl,
	input wire logic i_sda,
	dcdac_line_if.src line
);
	import dcdac_pkg::*;

	// Bit 0 is scl, bit 1 is sda; stage 0 feeds only stage 1
	logic [1:0] pipe_r [3];

	// ----------------------------------------------------------------
	// Synchroniser
	// ----------------------------------------------------------------
	// Reset to released lines so no false condition shows after reset
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			for (int i = 0; i < 3; i++)
				pipe_r[i] <= `DCDAC_PIN_RST;
		end
		else
		begin
			pipe_r[0] <= {i_sda, i_scl};
			pipe_r[1] <= pipe_r[0];
			pipe_r[2] <= pipe_r[1];
		end
	end

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------
	assign line.scl = pipe_r[1][0];
	assign line.sda = pipe_r[1][1];
	assign line.scl_rise = pipe_r[1][0] && !pipe_r[2][0];
	assign line.scl_fall = !pipe_r[1][0] && pipe_r[2][0];
	// SDA moving while SCL stays high marks a condition
	assign line.start = pipe_r[1][0] && pipe_r[2][0] && pipe_r[2][1] && !pipe_r[1][1];
	assign line.stop = pipe_r[1][0] && pipe_r[2][0] && !pipe_r[2][1] && pipe_r[1][1];
endmodule // dcdac_pin_sync

`default_nettype wire

// ===== rtl/dcdac_pkg.sv
// Types shared by the dual current DAC serial control slave
`include "dcdac_consts.svh"
`default_nettype none

package dcdac_pkg;
	typedef logic [`DCDAC_MAG_W-1:0] dcdac_mag_t;

	typedef struct packed {
		logic source;
		dcdac_mag_t mag;
	} dcdac_setting_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_REG,
		ST_DATA,
		ST_ACK,
		ST_READ,
		ST_READ_ACK,
		ST_IGNORE
	} dcdac_state_t;
endpackage

`default_nettype wire
